// File: mcu_instruction_subset_exec_test.sv
// self-checking bench for the instruction subset execution unit
// assumes mise_pkg and mise_exec are compiled first; bench is the decoder,
// the file register read port and the program memory all at once
`timescale 1ns/1ps
module mcu_instruction_subset_exec_test;
    logic clk, nrst, exec_valid, dest_sel, wake_up;
    logic [2:0] exec_op;
    logic [5:0] operand;
    logic [7:0] imm, file_rdata, table_pointer_high;
    logic [13:0] rom_rdata;
    logic file_wr, sfr_wr, zero_flag, digit_carry_flag, carry_flag;
    logic timeout_status_bit, power_down_status_bit, halt_mode;
    logic watchdog_clear, watchdog_prescaler_clear, rom_rd, fetch_hold;
    logic [5:0] file_waddr, table_data_high;
    logic [7:0] file_wdata, sfr_wdata, acc;
    logic [3:0] sfr_addr;
    logic [8:0] rom_addr;
    int bad_count = 0;
    int n_checks = 0;

    mise_exec dut (.clk(clk), .nrst(nrst), .exec_valid(exec_valid),
        .exec_op(exec_op), .operand(operand), .dest_sel(dest_sel),
        .imm(imm), .file_rdata(file_rdata),
        .table_pointer_high(table_pointer_high), .rom_rdata(rom_rdata),
        .wake_up(wake_up), .file_wr(file_wr), .file_waddr(file_waddr),
        .file_wdata(file_wdata), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .acc(acc), .zero_flag(zero_flag),
        .digit_carry_flag(digit_carry_flag), .carry_flag(carry_flag),
        .timeout_status_bit(timeout_status_bit),
        .power_down_status_bit(power_down_status_bit),
        .watchdog_clear(watchdog_clear),
        .watchdog_prescaler_clear(watchdog_prescaler_clear),
        .halt_mode(halt_mode), .rom_rd(rom_rd), .rom_addr(rom_addr),
        .table_data_high(table_data_high), .fetch_hold(fetch_hold));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // flags checked as {zero, digit carry, carry}
    task automatic chk_flags(input logic [2:0] exp);
        chk({13'h0000, zero_flag, digit_carry_flag, carry_flag},
            {13'h0000, exp}, "flags");
    endtask

    // one instruction, results sampled in the cycle after the issue edge
    task automatic run_op(input logic [2:0] op, input logic [5:0] opd,
                          input logic d, input logic [7:0] iv,
                          input logic [7:0] fr);
        @(posedge clk);
        exec_valid <= 1'b1;
        exec_op <= op;
        operand <= opd;
        dest_sel <= d;
        imm <= iv;
        file_rdata <= fr;
        @(posedge clk);
        exec_valid <= 1'b0;
        file_rdata <= ~fr;
        #1;
    endtask

    // hang guard: far beyond the length of the sequence below
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        exec_valid = 1'b0;
        exec_op = 3'h7;
        operand = 6'h00;
        dest_sel = 1'b0;
        imm = 8'h00;
        file_rdata = 8'h00;
        table_pointer_high = 8'h01;
        rom_rdata = 14'h0a55;
        wake_up = 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk(acc, 8'h00, "acc after reset");
        chk({timeout_status_bit, power_down_status_bit}, 2'h3, "status");
        run_op(mise_pkg::OP_SUB_IMM_MINUS_ACC, 6'h00, 1'b1, 8'h06, 8'h77);
        chk(acc, 8'h06, "imm minus acc");
        chk_flags(3'h3);
        chk(file_wr, 1'b0, "imm op wrote file");
        run_op(mise_pkg::OP_SUB_REG_MINUS_ACC, 6'h3f, 1'b1, 8'h00, 8'h05);
        chk({file_wr, file_waddr, file_wdata}, 15'h7fff, "reg wb");
        chk(acc, 8'h06, "acc kept on d=1");
        chk_flags(3'h0);
        run_op(mise_pkg::OP_SUB_REG_MINUS_ACC, 6'h00, 1'b0, 8'h00, 8'h06);
        chk({file_wr, acc}, 9'h000, "reg minus acc to acc");
        chk_flags(3'h7);
        run_op(mise_pkg::OP_NIBBLE_SWAP, 6'h2a, 1'b1, 8'h00, 8'ha5);
        chk({file_wr, file_waddr, file_wdata}, 15'h6a5a, "swap wb");
        run_op(mise_pkg::OP_NIBBLE_SWAP, 6'h01, 1'b0, 8'h00, 8'h3c);
        chk({file_wr, acc}, 9'h0c3, "swap to acc");
        chk_flags(3'h7);
        run_op(mise_pkg::OP_SPECIAL_PAGE_STORE, 6'h0f, 1'b0, 8'h00, 8'h00);
        chk({sfr_wr, sfr_addr, sfr_wdata}, 13'h1fc3, "store 15");
        chk_flags(3'h7);
        run_op(mise_pkg::OP_SPECIAL_PAGE_STORE, 6'h06, 1'b0, 8'h00, 8'h00);
        chk(sfr_wr, 1'b0, "store 6 dropped");
        run_op(mise_pkg::OP_SPECIAL_PAGE_STORE, 6'h07, 1'b0, 8'h00, 8'h00);
        chk({sfr_wr, sfr_addr, sfr_wdata}, 13'h17c3, "store 7");
        run_op(mise_pkg::OP_SUB_IMM_MINUS_ACC, 6'h00, 1'b0, 8'hf7, 8'h00);
        chk(acc, 8'h34, "acc preset");
        chk_flags(3'h3);
        // table read; a halt offered in the hold cycle must be ignored
        @(posedge clk);
        exec_valid <= 1'b1;
        exec_op <= mise_pkg::OP_PROGRAM_TABLE_READ;
        #1;
        chk({rom_rd, rom_addr}, 10'h334, "table address");
        @(posedge clk);
        exec_op <= mise_pkg::OP_HALT;
        rom_rdata <= 14'h35aa;
        #1;
        chk(fetch_hold, 1'b1, "hold in second cycle");
        @(posedge clk);
        exec_valid <= 1'b0;
        rom_rdata <= 14'h0a55;
        table_pointer_high <= 8'hfe;
        #1;
        chk(acc, 8'haa, "table low byte");
        chk(table_data_high, 6'h35, "table high bits");
        chk({fetch_hold, halt_mode}, 2'h0, "held op ignored");
        chk({rom_rd, rom_addr}, 10'h0aa, "pointer bit 0 only");
        run_op(mise_pkg::OP_HALT, 6'h00, 1'b0, 8'h00, 8'h00);
        chk({watchdog_clear, watchdog_prescaler_clear}, 2'h3, "wd");
        chk(halt_mode, 1'b1, "halt mode");
        chk({timeout_status_bit, power_down_status_bit}, 2'h2, "st");
        chk_flags(3'h3);
        @(posedge clk);
        wake_up <= 1'b1;
        #1;
        chk({watchdog_clear, watchdog_prescaler_clear}, 2'h0, "wd1");
        @(posedge clk);
        wake_up <= 1'b0;
        #1;
        chk(halt_mode, 1'b0, "wake up");
        chk({timeout_status_bit, power_down_status_bit}, 2'h2, "st2");
        finish_test();
    end
endmodule // mcu_instruction_subset_exec_test

// File: mise_exec.sv
// execution unit for six core instructions: special page store, halt,
// register minus accumulator, nibble swap, immediate minus accumulator
// and the two-cycle program table read.
// assumes the decoder presents one instruction per cycle with exec_valid,
// file_rdata carries the addressed file register in the same cycle, and
// program memory answers rom_rd with rom_rdata in the following cycle.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module mise_exec (
    input wire logic clk,
    input wire logic nrst,
    input wire logic exec_valid,
    input wire logic [2:0] exec_op,
    input wire logic [5:0] operand,
    input wire logic dest_sel,
    input wire logic [7:0] imm,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] table_pointer_high,
    input wire logic [13:0] rom_rdata,
    input wire logic wake_up,
    output logic file_wr,
    output logic [5:0] file_waddr,
    output logic [7:0] file_wdata,
    output logic sfr_wr,
    output logic [3:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output logic [7:0] acc,
    output logic zero_flag,
    output logic digit_carry_flag,
    output logic carry_flag,
    output logic timeout_status_bit,
    output logic power_down_status_bit,
    output logic watchdog_clear,
    output logic watchdog_prescaler_clear,
    output logic halt_mode,
    output logic rom_rd,
    output logic [8:0] rom_addr,
    output logic [5:0] table_data_high,
    output logic fetch_hold
);
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    mise_pkg::mise_state_t state_reg;
    logic [7:0] acc_reg;
    logic issue;
    logic do_store;
    logic do_halt;
    logic do_subr;
    logic do_swap;
    logic do_subi;
    logic do_table;
    logic [7:0] sub_a;
    logic [8:0] sub_full;
    logic [4:0] sub_low;
    logic [7:0] swap_res;
    logic [7:0] alu_res;

    // a table read in flight blocks issue; the decoder sees fetch_hold
    assign issue = exec_valid && (state_reg == mise_pkg::MISE_ST_IDLE);
    assign do_store = issue && (exec_op == mise_pkg::OP_SPECIAL_PAGE_STORE)
        && (operand[3:0] >= mise_pkg::SPECIAL_PAGE_MIN)
        && (operand[3:0] <= mise_pkg::SPECIAL_PAGE_MAX)
        && (operand[5:4] == 2'h0);
    assign do_halt = issue && (exec_op == mise_pkg::OP_HALT);
    assign do_subr = issue && (exec_op == mise_pkg::OP_SUB_REG_MINUS_ACC);
    assign do_swap = issue && (exec_op == mise_pkg::OP_NIBBLE_SWAP);
    assign do_subi = issue && (exec_op == mise_pkg::OP_SUB_IMM_MINUS_ACC);
    assign do_table = issue && (exec_op == mise_pkg::OP_PROGRAM_TABLE_READ);

    // ----------------------------------------------------------------
    // arithmetic
    // ----------------------------------------------------------------
    // subtraction as a + ~acc + 1 so carry means no borrow
    assign sub_a = do_subi ? imm : file_rdata;
    assign sub_full = {1'b0, sub_a} + {1'b0, ~acc_reg} + 9'h001;
    assign sub_low = {1'b0, sub_a[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
    assign swap_res = {file_rdata[3:0], file_rdata[7:4]};
    assign alu_res = do_swap ? swap_res : sub_full[7:0];

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= mise_pkg::MISE_ST_IDLE;
        end else begin
            unique case (state_reg)
                mise_pkg::MISE_ST_IDLE: begin
                    if (do_table) begin
                        state_reg <= mise_pkg::MISE_ST_TABLE;
                    end
                end
                mise_pkg::MISE_ST_TABLE: begin
                    state_reg <= mise_pkg::MISE_ST_IDLE;
                end
            endcase
        end
    end

    // memory port is busy with the data read, so no fetch this cycle
    assign fetch_hold = (state_reg == mise_pkg::MISE_ST_TABLE);
    assign rom_rd = do_table;
    assign rom_addr = {table_pointer_high[0], acc_reg};

    // ----------------------------------------------------------------
    // accumulator
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc_reg <= mise_pkg::ACC_RESET;
        end else if (fetch_hold) begin
            acc_reg <= rom_rdata[mise_pkg::ROM_LOW_MSB:0];
        end else if (do_subi) begin
            acc_reg <= sub_full[7:0];
        end else if ((do_subr || do_swap)
            && dest_sel == mise_pkg::DEST_ACC) begin
            acc_reg <= alu_res;
        end
    end
    assign acc = acc_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            table_data_high <= mise_pkg::TABLE_DATA_HIGH_RESET;
        end else if (fetch_hold) begin
            table_data_high <= rom_rdata[mise_pkg::ROM_HIGH_MSB:
                mise_pkg::ROM_HIGH_LSB];
        end
    end

    // ----------------------------------------------------------------
    // file register write back
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            file_wr <= 1'b0;
            file_waddr <= 6'h00;
            file_wdata <= 8'h00;
        end else begin
            file_wr <= (do_subr || do_swap)
                && dest_sel == mise_pkg::DEST_FILE;
            if (do_subr || do_swap) begin
                file_waddr <= operand;
                file_wdata <= alu_res;
            end
        end
    end

    // ----------------------------------------------------------------
    // special page store
    // ----------------------------------------------------------------
    // out-of-range page operands are dropped rather than aliased
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sfr_wr <= 1'b0;
            sfr_addr <= 4'h0;
            sfr_wdata <= 8'h00;
        end else begin
            sfr_wr <= do_store;
            if (do_store) begin
                sfr_addr <= operand[3:0];
                sfr_wdata <= acc_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // arithmetic flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            zero_flag <= 1'b0;
            digit_carry_flag <= 1'b0;
            carry_flag <= 1'b0;
        end else if (do_subr || do_subi) begin
            zero_flag <= (sub_full[7:0] == 8'h00);
            digit_carry_flag <= sub_low[4];
            carry_flag <= sub_full[8];
        end
    end

    // ----------------------------------------------------------------
    // halt, watchdog and power status
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timeout_status_bit <= mise_pkg::TIMEOUT_RESET;
            power_down_status_bit <= mise_pkg::POWER_DOWN_RESET;
            watchdog_clear <= 1'b0;
            watchdog_prescaler_clear <= 1'b0;
        end else begin
            watchdog_clear <= do_halt;
            watchdog_prescaler_clear <= do_halt;
            if (do_halt) begin
                timeout_status_bit <= mise_pkg::TIMEOUT_ON_HALT;
                power_down_status_bit <= mise_pkg::POWER_DOWN_ON_HALT;
            end
        end
    end

    // halt entry wins over a wake in the same cycle so it is not lost
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            halt_mode <= 1'b0;
        end else if (do_halt) begin
            halt_mode <= 1'b1;
        end else if (wake_up) begin
            halt_mode <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_store_copies_acc: assert property (
        do_store |=> sfr_wr && sfr_wdata == $past(acc_reg)
            && sfr_addr == $past(operand[3:0]) && $stable(carry_flag))
        else $error("special store did not copy accumulator");
    chk_store_range: assert property (
        sfr_wr |-> sfr_addr >= mise_pkg::SPECIAL_PAGE_MIN)
        else $error("special store outside page range");
    chk_halt_effects: assert property (
        do_halt |=> halt_mode && watchdog_clear && watchdog_prescaler_clear
            ##1 !watchdog_clear)
        else $error("halt did not clear watchdog or enter halt");
    chk_halt_status: assert property (
        do_halt |=> timeout_status_bit && !power_down_status_bit
            && $stable(zero_flag) && $stable(acc_reg))
        else $error("halt status bits wrong");
    chk_subr_result: assert property (
        do_subr && !dest_sel |=>
            acc_reg == 8'($past(file_rdata) - $past(acc_reg))
            && carry_flag == ($past(file_rdata) >= $past(acc_reg)))
        else $error("register minus accumulator wrong");
    chk_dest_file: assert property (
        (do_subr || do_swap) && dest_sel |=>
            file_wr && file_waddr == $past(operand) && $stable(acc_reg))
        else $error("destination select to file ignored");
    chk_swap_nibbles: assert property (
        do_swap |=> file_wdata == {$past(file_rdata[3:0]),
            $past(file_rdata[7:4])} && $stable(zero_flag))
        else $error("nibble swap wrong");
    chk_subi_result: assert property (
        do_subi |=> acc_reg == 8'($past(imm) - $past(acc_reg))
            && zero_flag == ($past(imm) == $past(acc_reg)) && !file_wr)
        else $error("immediate minus accumulator wrong");
    chk_table_two_cycle: assert property (
        do_table |=> fetch_hold ##1 !fetch_hold
            && acc_reg == $past(rom_rdata[7:0])
            && table_data_high == $past(rom_rdata[13:8]))
        else $error("table read sequence wrong");
    chk_table_addr: assert property (
        rom_rd |-> rom_addr == {table_pointer_high[0], acc_reg})
        else $error("table read address wrong");
    chk_store_dropped: assert property (
        issue && exec_op == mise_pkg::OP_SPECIAL_PAGE_STORE
            && operand[3:0] < mise_pkg::SPECIAL_PAGE_MIN |=> !sfr_wr)
        else $error("out of range special store was written");
    chk_subr_flags: assert property (
        do_subr |=> zero_flag == ($past(file_rdata) == $past(acc_reg))
            && digit_carry_flag
                == ($past(file_rdata[3:0]) >= $past(acc_reg[3:0])))
        else $error("register minus accumulator flags wrong");
    chk_subi_flags: assert property (
        do_subi |=> carry_flag == ($past(imm) >= $past(acc_reg))
            && digit_carry_flag
                == ($past(imm[3:0]) >= $past(acc_reg[3:0])))
        else $error("immediate minus accumulator flags wrong");
    chk_swap_to_acc: assert property (
        do_swap && !dest_sel |=>
            acc_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
            && !file_wr && $stable(carry_flag))
        else $error("nibble swap to accumulator wrong");
    chk_file_wr_dest: assert property (
        file_wr |-> $past(dest_sel) == mise_pkg::DEST_FILE
            && ($past(exec_op) == mise_pkg::OP_SUB_REG_MINUS_ACC
                || $past(exec_op) == mise_pkg::OP_NIBBLE_SWAP))
        else $error("file written for wrong destination");
    // an op offered during the hold must leave no trace
    chk_hold_ignores_op: assert property (
        fetch_hold |=> !fetch_hold && !file_wr && !sfr_wr
            && !watchdog_clear && !$rose(halt_mode))
        else $error("instruction issued during table hold");

    cov_halt: cover property (do_halt ##1 wake_up);
    cov_table_back: cover property (do_table ##2 do_table);
    cov_sub_zero: cover property (do_subr ##1 zero_flag && carry_flag);
    cov_store: cover property (do_store && operand[3:0] == 4'hf);
    cov_swap_acc: cover property (do_swap && !dest_sel);
endmodule // mise_exec

// File: mise_pkg.sv
// constants shared by the instruction subset execution unit
// assumes a single 40 MHz instruction clock and an external decoder
package mise_pkg;
    // --------------------------------------------------------------
    // operation codes presented by the decoder on exec_op
    // --------------------------------------------------------------
    localparam logic [2:0] OP_SPECIAL_PAGE_STORE = 3'h0;
    localparam logic [2:0] OP_HALT = 3'h1;
    localparam logic [2:0] OP_SUB_REG_MINUS_ACC = 3'h2;
    localparam logic [2:0] OP_NIBBLE_SWAP = 3'h3;
    localparam logic [2:0] OP_SUB_IMM_MINUS_ACC = 3'h4;
    localparam logic [2:0] OP_PROGRAM_TABLE_READ = 3'h5;

    // --------------------------------------------------------------
    // operand limits and field layout
    // --------------------------------------------------------------
    localparam logic [3:0] SPECIAL_PAGE_MIN = 4'h7;
    localparam logic [3:0] SPECIAL_PAGE_MAX = 4'hf;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam int ROM_LOW_MSB = 7;
    localparam int ROM_HIGH_LSB = 8;
    localparam int ROM_HIGH_MSB = 13;
    localparam int TABLE_DATA_HIGH_BITS = 6;

    // --------------------------------------------------------------
    // reset values and the status values loaded by halt
    // --------------------------------------------------------------
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [5:0] TABLE_DATA_HIGH_RESET = 6'h00;
    localparam logic TIMEOUT_RESET = 1'b1;
    localparam logic POWER_DOWN_RESET = 1'b1;
    localparam logic TIMEOUT_ON_HALT = 1'b1;
    localparam logic POWER_DOWN_ON_HALT = 1'b0;

    // --------------------------------------------------------------
    // execution sequencer
    // --------------------------------------------------------------
    typedef enum logic {
        MISE_ST_IDLE,
        MISE_ST_TABLE
    } mise_state_t;
endpackage
